/* File: include/line_ctrl_regs.svh */
/*
 Constants of the line transceiver control register: byte field positions,
 select codes, reset and default-mode images, serial frame geometry.
 Assumes a serial control channel carrying one control byte per frame.
*/
// Functional notes
// - A control byte is loaded into the control register only when both select bits are zero.
// - With bit 4 clear only the rate-dependent signalling bits go out in their normal places.
// - With bit 4 set all eight signalling bits go out in the first bearer slot.
// - With bit 6 set the echo canceller converges much faster than normal.
// - With bit 6 clear the echo canceller converges at its normal slower rate.
// - With bit 7 clear a zero is sent as the housekeeping bit of each line frame.
// - With bit 7 set a one is sent as the housekeeping bit of each line frame.
// - A byte with select bits one then zero goes to the diagnostics register instead.
// - A control write with bits 4 to 7 all one loads the default mode chosen by bit 3.
`ifndef LINE_CTRL_REGS_SVH
`define LINE_CTRL_REGS_SVH

`define LC_SEL_MSB 1
`define LC_SEL_LSB 0
`define LC_SEL_CTRL 2'b00
`define LC_SEL_DIAG 2'b10
`define LC_BIT_RATE 3
`define LC_BIT_BEARER_SIG 4
`define LC_BIT_FAST 6
`define LC_BIT_HK 7
`define LC_DFLT_MSB 7
`define LC_DFLT_LSB 4
`define LC_DFLT_KEY 4'hf
`define LC_RESET_VAL 8'h00
`define LC_DFLT1_VAL 8'h00
`define LC_DFLT2_VAL 8'h08
`define LC_DIAG_RESET 8'h00
`define LC_FRAME_BITS 256
`define LC_CTRL_CHAN 0
`define LC_CHAN_BITS 8
`define LC_FAST_FRAMES_HI 240
`define LC_FAST_FRAMES_LO 480

`endif

/* File: include/line_ctrl_pkg.sv */
/*
 Types of the line transceiver control register block.
 Assumes the constants header is compiled alongside.
*/
package line_ctrl_pkg;

	typedef enum logic [1:0] {
		ST_HUNT = 2'b00,
		ST_COUNT = 2'b01
	} frame_state_t;

	typedef struct packed {
		logic fast_converge;
		logic tx_housekeeping_bit;
		logic signalling_in_bearer_slot;
		logic line_rate_select;
	} ctrl_fields_t;

	typedef struct packed {
		logic [1:0] bits;
		logic [1:0] count;
		logic [7:0] bearer_byte;
		logic bearer_valid;
	} sig_out_t;

	typedef struct packed {
		frame_state_t state;
		logic [7:0] bit_pos;
		logic [7:0] shift;
		logic [7:0] ctrl;
		logic [7:0] diag;
		ctrl_fields_t fields;
		logic default_mode;
		logic ctrl_loaded;
		sig_out_t sig;
		logic hk_valid;
		logic hk_bit;
		logic [3:0] conv_shift;
	} lc_state_t;

endpackage

/* File: verilog/line_transceiver_control_register.sv */
/*
 Control register of a two-wire line transceiver, loaded from the serial
 control channel once per frame, and the line-side effects of its fields:
 rate select, signalling placement, echo canceller step and housekeeping bit.
 Assumes frame_pulse and bit_strobe are one-cycle enables synchronous to clk,
 frame_pulse coinciding with the strobe of the first bit of a frame, and the
 control byte arriving most significant bit first.
 Select bits 1:0 route a byte: 00 to the control register, bit 1 alone to
 the diagnostics byte, any other code is dropped.
 A control byte with the top nibble all ones loads a default image instead,
 its rate taken from bit 3; the default flag stays up until the next load.
 Bit 2 is kept in the stored byte only; bit 5 acts only as part of the default key.
 The diagnostics byte is stored raw, select bits included, and not decoded.
 FRAME_BITS must reach past the control slot, or no byte is ever loaded.
 Without a frame pulse the bit count wraps on its own, so a missing pulse
 keeps the slot in place as long as the frame length matches.
 The echo step shift lags the stored fast bit by one cycle.
 Signalling outputs except sig_bearer_valid, a one-cycle pulse, hold until the next d_channel_valid.
 Housekeeping bit is taken from the stored field at each line frame start.
*/
`timescale 1ns/1ps
`include "line_ctrl_regs.svh"

module line_transceiver_control_register
	import line_ctrl_pkg::*;
#(
	parameter int FRAME_BITS = `LC_FRAME_BITS,
	parameter int CTRL_CHAN = `LC_CTRL_CHAN,
	parameter logic [3:0] FAST_SHIFT = 4'h2,
	parameter logic [3:0] NORMAL_SHIFT = 4'h8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic frame_pulse,
	input wire logic bit_strobe,
	input wire logic serial_in,
	input wire logic [7:0] d_channel_in,
	input wire logic d_channel_valid,
	input wire logic line_frame_start,
	output logic [7:0] line_control,
	output logic [7:0] diag_control,
	output logic line_rate_select,
	output logic signalling_in_bearer_slot,
	output logic fast_converge,
	output logic tx_housekeeping_bit,
	output logic default_mode,
	output logic ctrl_loaded,
	output logic [1:0] sig_normal_bits,
	output logic [1:0] sig_normal_count,
	output logic [7:0] sig_bearer_byte,
	output logic sig_bearer_valid,
	output logic hk_valid,
	output logic hk_bit,
	output logic [3:0] echo_step_shift
);

	localparam logic [7:0] SLOT_FIRST = 8'((CTRL_CHAN * `LC_CHAN_BITS) % FRAME_BITS);
	localparam logic [7:0] SLOT_LAST = 8'(SLOT_FIRST + `LC_CHAN_BITS - 1);
	localparam logic [7:0] LAST_POS = 8'(FRAME_BITS - 1);

	lc_state_t cur_reg;
	lc_state_t cur_next;

	// Field image of a control byte
	function automatic ctrl_fields_t decode_fields(input logic [7:0] b);
		ctrl_fields_t f;
		f.line_rate_select = b[`LC_BIT_RATE];
		f.signalling_in_bearer_slot = b[`LC_BIT_BEARER_SIG];
		f.fast_converge = b[`LC_BIT_FAST];
		f.tx_housekeeping_bit = b[`LC_BIT_HK];
		return f;
	endfunction

	// Key pattern in the top nibble asks for a default mode
	function automatic logic is_default(input logic [7:0] b);
		return b[`LC_DFLT_MSB:`LC_DFLT_LSB] == `LC_DFLT_KEY;
	endfunction

	// Select bits of a received control-channel byte
	function automatic logic [1:0] sel_code(input logic [7:0] b);
		return b[`LC_SEL_MSB:`LC_SEL_LSB];
	endfunction

	logic [7:0] rx_byte;
	logic slot_done;
	logic [7:0] new_ctrl;

	always_comb begin
		rx_byte = {cur_reg.shift[6:0], serial_in};
		slot_done = 1'b0;
		new_ctrl = cur_reg.ctrl;
		cur_next = cur_reg;
		cur_next.ctrl_loaded = 1'b0;
		cur_next.sig.bearer_valid = 1'b0;
		cur_next.hk_valid = 1'b0;

		// Frame bit position tracking
		if (bit_strobe) begin
			if (frame_pulse) begin
				cur_next.state = ST_COUNT;
				cur_next.bit_pos = 8'h00;
			end else begin
				case (cur_reg.state)
					ST_HUNT: begin
						cur_next.bit_pos = 8'h00;
					end
					ST_COUNT: begin
						// Wraps without a pulse; the next pulse realigns
						if (cur_reg.bit_pos == LAST_POS) begin
							cur_next.bit_pos = 8'h00;
						end else begin
							cur_next.bit_pos = cur_reg.bit_pos + 8'h01;
						end
					end
					default: begin
						cur_next.state = ST_HUNT;
						cur_next.bit_pos = 8'h00;
					end
				endcase
			end
		end

		// Shift in control channel bits; one slot per frame only
		if (bit_strobe && (cur_reg.state == ST_COUNT || frame_pulse)) begin
			if (frame_pulse) begin
				if (SLOT_FIRST == 8'h00) begin
					cur_next.shift = {7'h00, serial_in};
				end
				slot_done = (SLOT_LAST == 8'h00);
			end else if (cur_next.bit_pos >= SLOT_FIRST && cur_next.bit_pos <= SLOT_LAST) begin
				cur_next.shift = rx_byte;
				slot_done = (cur_next.bit_pos == SLOT_LAST);
			end
		end

		// Route the completed byte by its select bits
		if (slot_done) begin
			if (sel_code(rx_byte) == `LC_SEL_CTRL) begin
				if (is_default(rx_byte)) begin
					new_ctrl = rx_byte[`LC_BIT_RATE] ? `LC_DFLT2_VAL : `LC_DFLT1_VAL;
					cur_next.default_mode = 1'b1;
				end else begin
					new_ctrl = rx_byte;
					cur_next.default_mode = 1'b0;
				end
				cur_next.ctrl = new_ctrl;
				cur_next.fields = decode_fields(new_ctrl);
				cur_next.ctrl_loaded = 1'b1;
			end else begin
				// Other select codes: control register left as is
				cur_next.ctrl = cur_reg.ctrl;
				if (sel_code(rx_byte) == `LC_SEL_DIAG) begin
					cur_next.diag = rx_byte;
				end
			end
		end

		// Signalling placement follows the stored fields
		if (d_channel_valid) begin
			if (cur_reg.fields.signalling_in_bearer_slot) begin
				cur_next.sig.bearer_byte = d_channel_in;
				cur_next.sig.bearer_valid = 1'b1;
				cur_next.sig.bits = 2'b00;
				cur_next.sig.count = 2'h0;
			end else if (cur_reg.fields.line_rate_select) begin
				cur_next.sig.bits = d_channel_in[1:0];
				cur_next.sig.count = 2'h2;
			end else begin
				cur_next.sig.bits = {1'b0, d_channel_in[0]};
				cur_next.sig.count = 2'h1;
			end
		end

		// Housekeeping bit sampled once per line frame
		if (line_frame_start) begin
			cur_next.hk_valid = 1'b1;
			cur_next.hk_bit = cur_reg.fields.tx_housekeeping_bit;
		end

		// Smaller shift means a larger adaptation step
		if (cur_reg.fields.fast_converge) begin
			cur_next.conv_shift = FAST_SHIFT;
		end else begin
			cur_next.conv_shift = NORMAL_SHIFT;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cur_reg.state <= ST_HUNT;
			cur_reg.bit_pos <= 8'h00;
			cur_reg.shift <= 8'h00;
			cur_reg.ctrl <= `LC_RESET_VAL;
			cur_reg.diag <= `LC_DIAG_RESET;
			cur_reg.fields <= '0;
			cur_reg.default_mode <= 1'b0;
			cur_reg.ctrl_loaded <= 1'b0;
			cur_reg.sig <= '0;
			cur_reg.hk_valid <= 1'b0;
			cur_reg.hk_bit <= 1'b0;
			cur_reg.conv_shift <= NORMAL_SHIFT;
		end else begin
			cur_reg <= cur_next;
		end
	end

	assign line_control = cur_reg.ctrl;
	assign diag_control = cur_reg.diag;
	assign line_rate_select = cur_reg.fields.line_rate_select;
	assign signalling_in_bearer_slot = cur_reg.fields.signalling_in_bearer_slot;
	assign fast_converge = cur_reg.fields.fast_converge;
	assign tx_housekeeping_bit = cur_reg.fields.tx_housekeeping_bit;
	assign default_mode = cur_reg.default_mode;
	assign ctrl_loaded = cur_reg.ctrl_loaded;
	assign sig_normal_bits = cur_reg.sig.bits;
	assign sig_normal_count = cur_reg.sig.count;
	assign sig_bearer_byte = cur_reg.sig.bearer_byte;
	assign sig_bearer_valid = cur_reg.sig.bearer_valid;
	assign hk_valid = cur_reg.hk_valid;
	assign hk_bit = cur_reg.hk_bit;
	assign echo_step_shift = cur_reg.conv_shift;

endmodule

/* File: verif/line_ctrl_properties.sv */
/*
 Checker for the line control register block.
 Bound to every instance; sees only its ports.
*/
`timescale 1ns/1ps
module line_ctrl_properties #(
	parameter logic [3:0] FAST_SHIFT = 4'h2,
	parameter logic [3:0] NORMAL_SHIFT = 4'h8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] d_channel_in,
	input wire logic d_channel_valid,
	input wire logic line_frame_start,
	input wire logic [7:0] line_control,
	input wire logic line_rate_select,
	input wire logic signalling_in_bearer_slot,
	input wire logic fast_converge,
	input wire logic tx_housekeeping_bit,
	input wire logic default_mode,
	input wire logic ctrl_loaded,
	input wire logic [1:0] sig_normal_count,
	input wire logic [7:0] sig_bearer_byte,
	input wire logic sig_bearer_valid,
	input wire logic hk_valid,
	input wire logic hk_bit,
	input wire logic [3:0] echo_step_shift
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	field_map_a: assert property ({tx_housekeeping_bit, fast_converge} == line_control[7:6]
		&& {signalling_in_bearer_slot, line_rate_select} == line_control[4:3])
		else $error("field outputs differ from register");
	fast_step_a: assert property (fast_converge |=> echo_step_shift == FAST_SHIFT)
		else $error("fast step missing");
	slow_step_a: assert property (!fast_converge |=> echo_step_shift == NORMAL_SHIFT)
		else $error("normal step missing");
	hk_send_a: assert property (line_frame_start |=> hk_valid && hk_bit == $past(tx_housekeeping_bit))
		else $error("housekeeping bit wrong");
	load_only_a: assert property ($changed(line_control) |-> ctrl_loaded || $past(sys_rst))
		else $error("register changed without load");
	load_pulse_a: assert property (ctrl_loaded |=> !ctrl_loaded)
		else $error("load pulse too long");
	bearer_send_a: assert property (d_channel_valid && signalling_in_bearer_slot |=>
		sig_bearer_valid && sig_bearer_byte == $past(d_channel_in)) else $error("bearer byte wrong");
	normal_send_a: assert property (d_channel_valid && !signalling_in_bearer_slot |=>
		!sig_bearer_valid && sig_normal_count == ($past(line_rate_select) ? 2'h2 : 2'h1))
		else $error("normal signalling count wrong");
	default_img_a: assert property (ctrl_loaded && default_mode |->
		line_control[7:4] == 4'h0 && line_control[2:0] == 3'h0) else $error("default image wrong");
	cover property (ctrl_loaded && default_mode);
	cover property (sig_bearer_valid);
	cover property (hk_valid && hk_bit);
endmodule
bind line_transceiver_control_register line_ctrl_properties #(.FAST_SHIFT(FAST_SHIFT),
	.NORMAL_SHIFT(NORMAL_SHIFT)) i_line_ctrl_properties (.clk(clk), .sys_rst(sys_rst),
	.d_channel_in(d_channel_in), .d_channel_valid(d_channel_valid),
	.line_frame_start(line_frame_start), .line_control(line_control),
	.line_rate_select(line_rate_select), .signalling_in_bearer_slot(signalling_in_bearer_slot),
	.fast_converge(fast_converge), .tx_housekeeping_bit(tx_housekeeping_bit),
	.default_mode(default_mode), .ctrl_loaded(ctrl_loaded), .sig_normal_count(sig_normal_count),
	.sig_bearer_byte(sig_bearer_byte), .sig_bearer_valid(sig_bearer_valid),
	.hk_valid(hk_valid), .hk_bit(hk_bit), .echo_step_shift(echo_step_shift));

/* File: verif/ctrl_channel_model.sv */
/*
 System controller on the serial control channel: one byte per frame.
 Assumes a free clock; drives on the falling edge.
*/
`timescale 1ns/1ps
module ctrl_channel_model #(
	parameter int FRAME_BITS = 16
) (
	input wire logic clk,
	output logic frame_pulse,
	output logic bit_strobe,
	output logic serial_in
);
	initial begin
		frame_pulse = 1'b0;
		bit_strobe = 1'b0;
		serial_in = 1'b0;
	end
	// Gap spaces the strobes; idle line shows inverse so stale bits never pass
	task automatic send(input logic [7:0] b, input int gap);
		for (int i = 0; i < FRAME_BITS; i++) begin
			@(negedge clk);
			frame_pulse = (i == 0);
			bit_strobe = 1'b1;
			serial_in = (i < 8) ? b[7 - i] : ~serial_in;
			repeat (gap) begin
				@(negedge clk);
				{frame_pulse, bit_strobe} = 2'b00;
				serial_in = ~serial_in;
			end
		end
		@(negedge clk);
		{frame_pulse, bit_strobe} = 2'b00;
	endtask
endmodule

/* File: verif/testbench.sv */
/*
 Self-checking bench for the line control register block.
 Assumes the controller model and the bound checker are compiled.
*/
`timescale 1ns/1ps
`include "line_ctrl_regs.svh"
module testbench;
	import line_ctrl_pkg::*;
	logic clk = 1'b0, sys_rst = 1'b1, d_channel_valid = 1'b0, line_frame_start = 1'b0;
	logic frame_pulse, bit_strobe, serial_in, line_rate_select, signalling_in_bearer_slot;
	logic fast_converge, tx_housekeeping_bit, default_mode, ctrl_loaded;
	logic sig_bearer_valid, hk_valid, hk_bit;
	logic [7:0] d_channel_in = 8'ha7, line_control, diag_control, sig_bearer_byte;
	logic [1:0] sig_normal_bits, sig_normal_count;
	logic [3:0] echo_step_shift;
	logic [7:0] tx [8] = '{8'hc8, 8'h52, 8'h51, 8'h53, 8'hf8, 8'hf0, 8'h18, 8'h80};
	logic [7:0] ex [8] = '{8'hc8, 8'hc8, 8'hc8, 8'hc8, 8'h08, 8'h00, 8'h18, 8'h80};
	logic [7:0] diag_exp;
	int num_errors = 0, checked = 0, cycles = 0;
	always #10 clk = ~clk;
	ctrl_channel_model #(.FRAME_BITS(16)) i_ctrl_channel_model (.clk(clk),
		.frame_pulse(frame_pulse), .bit_strobe(bit_strobe), .serial_in(serial_in));
	line_transceiver_control_register #(.FRAME_BITS(16)) i_line_transceiver_control_register (
		.clk(clk), .sys_rst(sys_rst), .frame_pulse(frame_pulse), .bit_strobe(bit_strobe),
		.serial_in(serial_in), .d_channel_in(d_channel_in), .d_channel_valid(d_channel_valid),
		.line_frame_start(line_frame_start), .line_control(line_control),
		.diag_control(diag_control), .line_rate_select(line_rate_select),
		.signalling_in_bearer_slot(signalling_in_bearer_slot), .fast_converge(fast_converge),
		.tx_housekeeping_bit(tx_housekeeping_bit), .default_mode(default_mode),
		.ctrl_loaded(ctrl_loaded), .sig_normal_bits(sig_normal_bits),
		.sig_normal_count(sig_normal_count), .sig_bearer_byte(sig_bearer_byte),
		.sig_bearer_valid(sig_bearer_valid), .hk_valid(hk_valid), .hk_bit(hk_bit),
		.echo_step_shift(echo_step_shift));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("errors=%0d compares=%0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Ceiling well above 240 start-up frames of 17 cycles plus the test frames
	always @(posedge clk) begin
		cycles++;
		if (cycles == 8000) begin
			num_errors++;
			complete_run();
		end
	end
	initial begin
		diag_exp = 8'h00;
		repeat (4) @(negedge clk);
		sys_rst = 1'b0;
		check(line_control, 8'h00);
		check({4'h0, echo_step_shift}, 8'h08);
		repeat (`LC_FAST_FRAMES_HI) i_ctrl_channel_model.send(8'hc8, 0);
		check(line_control, 8'hc8);
		check({4'h0, echo_step_shift}, 8'h02);
		$display("start-up convergence phase done");
		for (int i = 0; i < 8; i++) begin
			i_ctrl_channel_model.send(tx[i], (i % 2) * 2);
			if (tx[i][1:0] == 2'b10)
				diag_exp = tx[i];
			check(line_control, ex[i]);
			check(diag_control, diag_exp);
			check({7'h0, default_mode}, {7'h0, tx[i][7:4] == 4'hf});
			check({4'h0, echo_step_shift}, ex[i][6] ? 8'h02 : 8'h08);
			check({4'h0, tx_housekeeping_bit, fast_converge, signalling_in_bearer_slot,
				line_rate_select}, {4'h0, ex[i][7:6], ex[i][4:3]});
			{d_channel_valid, line_frame_start} = 2'b11;
			@(negedge clk);
			{d_channel_valid, line_frame_start} = 2'b00;
			check({7'h0, hk_bit}, {7'h0, ex[i][7]});
			check({6'h0, sig_normal_count}, ex[i][4] ? 8'h0 : (ex[i][3] ? 8'h2 : 8'h1));
			check({7'h0, sig_bearer_valid}, {7'h0, ex[i][4]});
			check({7'h0, hk_valid}, 8'h01);
			check({6'h0, sig_normal_bits}, ex[i][4] ? 8'h00 : (ex[i][3] ? 8'h03 : 8'h01));
			if (ex[i][4])
				check(sig_bearer_byte, 8'ha7);
			$display("test %0d done, byte %h", i, tx[i]);
		end
		// One-cycle reset in mid-run, then a fresh load from the hunt state
		sys_rst = 1'b1;
		@(negedge clk);
		sys_rst = 1'b0;
		check(line_control, 8'h00);
		check(diag_control, 8'h00);
		check({7'h0, default_mode}, 8'h00);
		check({4'h0, echo_step_shift}, 8'h08);
		i_ctrl_channel_model.send(8'h48, 2);
		check(line_control, 8'h48);
		check({4'h0, echo_step_shift}, 8'h02);
		$display("mid-run reset test done");
		complete_run();
	end
endmodule
